// ### rtl/chgi2c_consts.vh
// Purpose: constants of the charger register port
// Assumes: included by the register port design file only
// Notes:   offsets are the documented subaddresses
`ifndef CHGI2C_CONSTS_VH
`define CHGI2C_CONSTS_VH
`define CHGI2C_ADDR_WR          8'h28
`define CHGI2C_ADDR_RD          8'h29
`define CHGI2C_DEV_ADDR7        7'h14
`define CHGI2C_REG_IDENT        8'h00
`define CHGI2C_REG_SIREV        8'h01
`define CHGI2C_REG_ILIM         8'h02
`define CHGI2C_REG_TERM         8'h03
`define CHGI2C_REG_ICHG         8'h04
`define CHGI2C_REG_VTHR         8'h05
`define CHGI2C_REG_TIMER        8'h06
`define CHGI2C_REG_FUNCA        8'h07
`define CHGI2C_REG_FUNCB        8'h08
`define CHGI2C_REG_IRQEN        8'h09
`define CHGI2C_REG_IRQPEND      8'h0a
`define CHGI2C_REG_STATA        8'h0b
`define CHGI2C_REG_STATB        8'h0c
`define CHGI2C_REG_FAULT        8'h0d
`define CHGI2C_REG_SHORT        8'h10
`define CHGI2C_REG_EOC          8'h11
`define CHGI2C_NUM_RW           10
// writable bit masks, zero where the map leaves a cell empty
`define CHGI2C_MASK_ILIM        8'h1f
`define CHGI2C_MASK_TERM        8'hff
`define CHGI2C_MASK_ICHG        8'h7f
`define CHGI2C_MASK_VTHR        8'hff
`define CHGI2C_MASK_TIMER       8'h3f
`define CHGI2C_MASK_FUNCA       8'h7d
`define CHGI2C_MASK_FUNCB       8'hff
`define CHGI2C_MASK_IRQEN       8'h7f
`define CHGI2C_MASK_SHORT       8'h77
`define CHGI2C_MASK_EOC         8'hff
// self-clearing watchdog reset bit of the timer register
`define CHGI2C_TIMER_WDRST_BIT  0
`define CHGI2C_MASK_IRQ         8'h7f
`endif

// ### rtl/chgi2c_bitrx.v
// Purpose: synchronise and edge-detect the two bus pins
// Assumes: pins are asynchronous to core_clk_i
// Notes:   first sync stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module chgi2c_bitrx (
	// clock and reset
	input  wire core_clk_i,
	input  wire rstn_i,
	input  wire clk_en_i,
	// raw pins
	input  wire scl_i,
	input  wire sda_i,
	// conditioned events
	output reg  scl_rise_o,
	output reg  scl_fall_o,
	output reg  start_o,
	output reg  stop_o,
	output reg  sda_o
);
	reg [1:0] scl_sync_ff;
	reg [1:0] sda_sync_ff;
	reg       scl_q_ff;
	reg       sda_q_ff;

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_q_ff    <= 1'b1;
			sda_q_ff    <= 1'b1;
			scl_rise_o  <= 1'b0;
			scl_fall_o  <= 1'b0;
			start_o     <= 1'b0;
			stop_o      <= 1'b0;
			sda_o       <= 1'b1;
		end else if (clk_en_i) begin
			scl_sync_ff <= {scl_sync_ff[0], scl_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_i};
			scl_q_ff    <= scl_sync_ff[1];
			sda_q_ff    <= sda_sync_ff[1];
			sda_o       <= sda_sync_ff[1];
			scl_rise_o  <= scl_sync_ff[1] & ~scl_q_ff;
			scl_fall_o  <= ~scl_sync_ff[1] & scl_q_ff;
			start_o     <= scl_sync_ff[1] & scl_q_ff &
			               ~sda_sync_ff[1] & sda_q_ff;
			stop_o      <= scl_sync_ff[1] & scl_q_ff &
			               sda_sync_ff[1] & ~sda_q_ff;
		end
	end
endmodule
`default_nettype wire

// ### rtl/chgi2c_regport.v
// Purpose: i2c target port and register bank of the charger
// Assumes: sda is open drain; status comes from charger logic
// Notes:   factory option defaults arrive on fuse_*_i
//
// Behaviour
// - answer address 0x28 write, 0x29 read
// - defaults restored when input falls below threshold
// - defaults restored on battery removal at 0 V
// - first data byte goes to subaddress register
// - acknowledge every received data byte
// - subaddress advances after each written byte
// - reads stream from subaddress, auto increment
// - flagged fields default on input connect/disconnect
// - flagged defaults come from factory option inputs
// - empty map bits have no function
// - ident: maker code high, part code low
`timescale 1ns/10ps
`default_nettype none
`include "chgi2c_consts.vh"
module chgi2c_regport #(
	parameter [3:0] MAKER_CODE = 4'h5, // arbitrary value
	parameter [3:0] PART_CODE  = 4'h6, // arbitrary value
	parameter [3:0] REV_CODE   = 4'h2  // arbitrary value
) (
	// clock and reset
	input  wire        core_clk_i,
	input  wire        rstn_i,
	input  wire        clk_en_i,
	// bus pins
	input  wire        scl_i,
	input  wire        sda_i,
	output reg         sda_o,
	output reg         sda_oe_o,
	// supply events, asynchronous levels
	input  wire        input_supply_ok_i,
	input  wire        batt_present_i,
	input  wire        input_supply_zero_i,
	// factory option defaults
	input  wire [79:0] fuse_default_i,
	// charger status and events
	input  wire [6:0]  irq_event_i,
	input  wire [7:0]  charger_state_a_i,
	input  wire [7:0]  charger_state_b_i,
	input  wire [7:0]  fault_flags_i,
	// configuration out, 10 rw registers 0x02..0x08,0x09,0x10,0x11
	output reg  [79:0] cfg_o,
	output reg         irq_o
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_SUB  = 3'h2;
	localparam [2:0] ST_WDAT = 3'h3;
	localparam [2:0] ST_RDAT = 3'h4;
	localparam [2:0] ST_RACK = 3'h5;
	localparam [2:0] ST_SKIP = 3'h6;

	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;
	wire sda_s;

	reg  [2:0] st_ff;
	reg  [3:0] bit_cnt_ff;
	reg  [7:0] shift_ff;
	reg  [7:0] sub_ff;
	reg        ack_ff;
	reg        drive_ff;
	reg  [7:0] tx_ff;
	reg  [6:0] pend_ff;
	reg  [2:0] ok_sync_ff;
	reg  [1:0] bp_sync_ff;
	reg  [1:0] vz_sync_ff;
	reg        bp_q_ff;
	reg        ok_q_ff;
	reg        init_ff;

	//////////////////////////////////////////////////////////////////////
	// pin conditioning
	chgi2c_bitrx u_bitrx (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.clk_en_i   (clk_en_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (bus_start),
		.stop_o     (bus_stop),
		.sda_o      (sda_s)
	);

	//////////////////////////////////////////////////////////////////////
	// register index and masks
	function [3:0] rw_index;
		input [7:0] a;
		begin
			case (a)
				`CHGI2C_REG_ILIM:  rw_index = 4'h0;
				`CHGI2C_REG_TERM:  rw_index = 4'h1;
				`CHGI2C_REG_ICHG:  rw_index = 4'h2;
				`CHGI2C_REG_VTHR:  rw_index = 4'h3;
				`CHGI2C_REG_TIMER: rw_index = 4'h4;
				`CHGI2C_REG_FUNCA: rw_index = 4'h5;
				`CHGI2C_REG_FUNCB: rw_index = 4'h6;
				`CHGI2C_REG_IRQEN: rw_index = 4'h7;
				`CHGI2C_REG_SHORT: rw_index = 4'h8;
				`CHGI2C_REG_EOC:   rw_index = 4'h9;
				default:           rw_index = 4'hf;
			endcase
		end
	endfunction

	function [7:0] rw_mask;
		input [3:0] i;
		begin
			case (i)
				4'h0:    rw_mask = `CHGI2C_MASK_ILIM;
				4'h1:    rw_mask = `CHGI2C_MASK_TERM;
				4'h2:    rw_mask = `CHGI2C_MASK_ICHG;
				4'h3:    rw_mask = `CHGI2C_MASK_VTHR;
				4'h4:    rw_mask = `CHGI2C_MASK_TIMER;
				4'h5:    rw_mask = `CHGI2C_MASK_FUNCA;
				4'h6:    rw_mask = `CHGI2C_MASK_FUNCB;
				4'h7:    rw_mask = `CHGI2C_MASK_IRQEN;
				4'h8:    rw_mask = `CHGI2C_MASK_SHORT;
				4'h9:    rw_mask = `CHGI2C_MASK_EOC;
				default: rw_mask = 8'h00;
			endcase
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// supply condition sync and default-restore trigger
	wire ok_rise = ok_sync_ff[1] & ~ok_q_ff;
	wire ok_fall = ~ok_sync_ff[1] & ok_q_ff;
	wire bp_fall = ~bp_sync_ff[1] & bp_q_ff;
	wire restore = init_ff | ok_fall | ok_rise |
	               (bp_fall & vz_sync_ff[1]);

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ok_sync_ff <= 3'h0;
			bp_sync_ff <= 2'h0;
			vz_sync_ff <= 2'h0;
			ok_q_ff    <= 1'b0;
			bp_q_ff    <= 1'b0;
			init_ff    <= 1'b1;
		end else if (clk_en_i) begin
			ok_sync_ff <= {ok_sync_ff[1:0], input_supply_ok_i};
			bp_sync_ff <= {bp_sync_ff[0], batt_present_i};
			vz_sync_ff <= {vz_sync_ff[0], input_supply_zero_i};
			ok_q_ff    <= ok_sync_ff[1];
			bp_q_ff    <= bp_sync_ff[1];
			init_ff    <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// read data select
	reg [7:0] rd_data;
	reg [3:0] rd_idx;
	always @* begin
		rd_idx  = rw_index(sub_ff);
		rd_data = 8'h00;
		case (sub_ff)
			`CHGI2C_REG_IDENT:   rd_data = {MAKER_CODE, PART_CODE};
			`CHGI2C_REG_SIREV:   rd_data = {4'h0, REV_CODE};
			`CHGI2C_REG_IRQPEND: rd_data = {1'b0, pend_ff &
			                      cfg_o[63:57]};
			`CHGI2C_REG_STATA:   rd_data = charger_state_a_i;
			`CHGI2C_REG_STATB:   rd_data = charger_state_b_i & 8'h77;
			`CHGI2C_REG_FAULT:   rd_data = fault_flags_i & 8'h0b;
			default: begin
				if (rd_idx != 4'hf)
					rd_data = cfg_o[rd_idx*8 +: 8] & rw_mask(rd_idx);
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// protocol engine
	wire       byte_done = scl_rise & (bit_cnt_ff == 4'h7);
	wire [7:0] rx_byte   = {shift_ff[6:0], sda_s};
	wire [3:0] wr_idx    = rw_index(sub_ff);
	reg        wr_en;

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_ff      <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff   <= 8'h00;
			sub_ff     <= 8'h00;
			ack_ff     <= 1'b0;
			drive_ff   <= 1'b0;
			tx_ff      <= 8'h00;
			sda_o      <= 1'b0;
			sda_oe_o   <= 1'b0;
			wr_en      <= 1'b0;
		end else if (clk_en_i) begin
			wr_en <= 1'b0;
			if (bus_stop) begin
				st_ff    <= ST_IDLE;
				sda_oe_o <= 1'b0;
				ack_ff   <= 1'b0;
				drive_ff <= 1'b0;
			end else if (bus_start) begin
				st_ff      <= ST_ADDR;
				bit_cnt_ff <= 4'h0;
				sda_oe_o   <= 1'b0;
				ack_ff     <= 1'b0;
				drive_ff   <= 1'b0;
			end else begin
				if (scl_rise && !ack_ff && !drive_ff) begin
					shift_ff   <= rx_byte;
					bit_cnt_ff <= bit_cnt_ff + 4'h1;
				end
				if (scl_fall) begin
					if (ack_ff) begin
						// release after the ack clock
						ack_ff     <= 1'b0;
						sda_oe_o   <= 1'b0;
						bit_cnt_ff <= 4'h0;
						if (st_ff == ST_RDAT) begin
							drive_ff <= 1'b1;
							tx_ff    <= {rd_data[6:0], 1'b0};
							sda_oe_o <= ~rd_data[7];
							bit_cnt_ff <= 4'h1;
						end
					end else if (drive_ff) begin
						if (bit_cnt_ff == 4'h8) begin
							drive_ff   <= 1'b0;
							sda_oe_o   <= 1'b0;
							st_ff      <= ST_RACK;
							bit_cnt_ff <= 4'h0;
						end else begin
							sda_oe_o   <= ~tx_ff[7];
							tx_ff      <= {tx_ff[6:0], 1'b0};
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end
					end else if (bit_cnt_ff == 4'h8) begin
						bit_cnt_ff <= 4'h0;
						case (st_ff)
							ST_ADDR: begin
								if (shift_ff == `CHGI2C_ADDR_WR) begin
									st_ff <= ST_SUB;
									ack_ff <= 1'b1;
									sda_oe_o <= 1'b1;
								end else if (shift_ff == `CHGI2C_ADDR_RD) begin
									st_ff <= ST_RDAT;
									ack_ff <= 1'b1;
									sda_oe_o <= 1'b1;
								end else begin
									st_ff <= ST_SKIP;
								end
							end
							ST_SUB: begin
								sub_ff   <= shift_ff;
								st_ff    <= ST_WDAT;
								ack_ff   <= 1'b1;
								sda_oe_o <= 1'b1;
							end
							ST_WDAT: begin
								ack_ff   <= 1'b1;
								sda_oe_o <= 1'b1;
								wr_en    <= 1'b1;
							end
							default: st_ff <= st_ff;
						endcase
					end
				end
				if (st_ff == ST_RACK && scl_rise) begin
					// host nack ends the read stream
					sub_ff <= sub_ff + 8'h01;
					st_ff  <= sda_s ? ST_SKIP : ST_RDAT;
					ack_ff <= ~sda_s;
				end
				if (wr_en)
					sub_ff <= sub_ff + 8'h01;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// register bank and pending events
	genvar g;
	generate
		for (g = 0; g < `CHGI2C_NUM_RW; g = g + 1) begin : g_reg
			always @(posedge core_clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					cfg_o[g*8 +: 8] <= 8'h00;
				end else if (clk_en_i) begin
					if (restore)
						cfg_o[g*8 +: 8] <= fuse_default_i[g*8 +: 8] &
						                   rw_mask(g);
					else if (wr_en && wr_idx == g)
						cfg_o[g*8 +: 8] <= shift_ff & rw_mask(g);
					else if (g == 4)
						cfg_o[g*8 + `CHGI2C_TIMER_WDRST_BIT] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pend_ff <= 7'h00;
			irq_o   <= 1'b0;
		end else if (clk_en_i) begin
			// set wins over clear-on-read
			if (st_ff == ST_RACK && scl_rise &&
			    sub_ff == `CHGI2C_REG_IRQPEND)
				pend_ff <= irq_event_i;
			else
				pend_ff <= pend_ff | irq_event_i;
			irq_o <= |(pend_ff & cfg_o[63:57]);
		end
	end
endmodule
`default_nettype wire

// ### verif/chgi2c_props.sv
// Purpose: assertions on the charger register port
// Assumes: bound to chgi2c_regport, all in one clock domain
// Notes:   M leaves out empty cells and the self-clearing timer bit
`timescale 1ns/10ps
`default_nettype none
module chgi2c_props (
	// clock and reset
	input wire        core_clk_i,
	input wire        rstn_i,
	// bus and supply
	input wire        scl_i,
	input wire        sda_o,
	input wire        sda_oe_o,
	input wire        input_supply_ok_i,
	input wire        batt_present_i,
	input wire        input_supply_zero_i,
	// defaults, config and irq
	input wire [79:0] fuse_default_i,
	input wire [6:0]  irq_event_i,
	input wire [79:0] cfg_o,
	input wire        irq_o
);
	localparam [79:0] M = 80'hff77_7fff_7d3e_ff7f_ff1f;
	wire dflt = (cfg_o & M) == (fuse_default_i & M);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	property p_rst_dflt; $rose(rstn_i) |-> ##[1:4] dflt; endproperty
	a_rst_dflt: assert property (p_rst_dflt)
		else $error("defaults not loaded after reset");
	property p_fall_dflt; $fell(input_supply_ok_i) |-> ##[1:8] dflt; endproperty
	a_fall_dflt: assert property (p_fall_dflt)
		else $error("defaults not restored on supply drop");
	property p_rise_dflt; $rose(input_supply_ok_i) |-> ##[1:8] dflt; endproperty
	a_rise_dflt: assert property (p_rise_dflt)
		else $error("defaults not restored on supply connect");
	property p_batt_dflt;
		$fell(batt_present_i) && input_supply_zero_i |-> ##[1:8] dflt;
	endproperty
	a_batt_dflt: assert property (p_batt_dflt)
		else $error("defaults not restored on battery removal");
	property p_irq_on; irq_event_i[0] && cfg_o[56] |-> ##[1:3] irq_o; endproperty
	a_irq_on: assert property (p_irq_on)
		else $error("enabled event gave no irq");
	property p_irq_off; (cfg_o[62:56] == 7'h00)[*3] |-> !irq_o; endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("irq with all enables off");
	property p_od; sda_oe_o |-> !sda_o; endproperty
	a_od: assert property (p_od)
		else $error("sda driven high");
	property p_ack_edge; $changed(sda_oe_o) |-> !scl_i; endproperty
	a_ack_edge: assert property (p_ack_edge)
		else $error("sda changed while scl high");
	c_ack: cover property ($rose(sda_oe_o));
	c_irq: cover property ($rose(irq_o));
	c_drop: cover property ($fell(input_supply_ok_i));
endmodule
bind chgi2c_regport chgi2c_props u_props (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .input_supply_ok_i(input_supply_ok_i),
	.batt_present_i(batt_present_i), .input_supply_zero_i(input_supply_zero_i),
	.fuse_default_i(fuse_default_i), .irq_event_i(irq_event_i),
	.cfg_o(cfg_o), .irq_o(irq_o));
`default_nettype wire

// ### verif/chgi2c_host.sv
// Purpose: bus master model standing in for the host controller
// Assumes: sda pulled up outside, this model only pulls low
// Notes:   HALF core cycles per scl high phase, HALF+4 per low phase
`timescale 1ns/10ps
`default_nettype none
module chgi2c_host #(
	parameter int HALF = 20
) (
	// clock
	input  wire logic core_clk_i,
	// bus
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic start_c;
		wt(4);
		sda_low_o = 1'b0;
		wt(HALF);
		scl_o = 1'b1;
		wt(HALF);
		sda_low_o = 1'b1;
		wt(HALF);
		scl_o = 1'b0;
	endtask
	task automatic stop_c;
		wt(4);
		sda_low_o = 1'b1;
		wt(HALF);
		scl_o = 1'b1;
		wt(HALF);
		sda_low_o = 1'b0;
		wt(HALF);
	endtask
	task automatic bit_x(input logic b, output logic r);
		wt(4);
		sda_low_o = !b;
		wt(HALF);
		scl_o = 1'b1;
		wt(HALF);
		r = sda_i;
		scl_o = 1'b0;
	endtask
	task automatic byte_x(input logic [7:0] d, input logic rel9,
	                      output logic [7:0] q, output logic r9);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], b);
			q[i] = b;
		end
		bit_x(rel9, r9);
	endtask
	task automatic wr(input logic [7:0] sub, input logic [31:0] d, input int n,
	                  output logic nak);
		logic [7:0] q;
		logic a;
		start_c;
		byte_x(8'h28, 1'b1, q, nak);
		byte_x(sub, 1'b1, q, a);
		nak = nak | a;
		for (int k = n - 1; k >= 0; k--) begin
			byte_x(d[8*k +: 8], 1'b1, q, a);
			nak = nak | a;
		end
		stop_c;
	endtask
	task automatic rd(input logic [7:0] sub, input int n,
	                  output logic [31:0] d, output logic nak);
		logic [7:0] q;
		logic a;
		d = '0;
		start_c;
		byte_x(8'h28, 1'b1, q, nak);
		byte_x(sub, 1'b1, q, a);
		nak = nak | a;
		start_c;
		byte_x(8'h29, 1'b1, q, a);
		nak = nak | a;
		for (int k = n - 1; k >= 0; k--) begin
			byte_x(8'hff, k == 0, q, a);
			d[8*k +: 8] = q;
		end
		stop_c;
	endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Purpose: self-checking bench of the charger register port
// Assumes: host model drives the bus, status inputs held steady
// Notes:   every factory default set to all ones
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk;
	logic        rstn;
	logic        vok;
	logic        batt;
	logic        vzero;
	logic [6:0]  evt;
	logic        scl;
	logic        hlow;
	logic        oe;
	logic [79:0] cfg;
	logic        irq;
	logic [31:0] got;
	logic        nak;
	logic        cen;
	logic [7:0]  flt;
	int          err_total;
	int          check_count;
	wire         sda = !(hlow | oe);
	// identity codes arbitrary
	chgi2c_regport #(.MAKER_CODE(4'h3), .PART_CODE(4'hc), .REV_CODE(4'h7)) u_dut (
		.core_clk_i(clk), .rstn_i(rstn), .clk_en_i(cen), .scl_i(scl),
		.sda_i(sda), .sda_o(), .sda_oe_o(oe), .input_supply_ok_i(vok),
		.batt_present_i(batt), .input_supply_zero_i(vzero),
		.fuse_default_i({10{8'hff}}), .irq_event_i(evt),
		.charger_state_a_i(8'h96), .charger_state_b_i(8'hff),
		.fault_flags_i(flt), .cfg_o(cfg), .irq_o(irq));
	chgi2c_host u_host (.core_clk_i(clk), .sda_i(sda), .scl_o(scl),
		.sda_low_o(hlow));
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic give_verdict;
		if (err_total == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		#1 evt[b] = 1'b1;
		@(posedge clk);
		#1 evt = 7'h00;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic settle;
		repeat (10) @(posedge clk);
		#1;
	endtask
	initial begin
		#400000;
		err_total++;
		give_verdict;
	end
	initial begin
		err_total = 0;
		check_count = 0;
		rstn = 1'b0;
		cen = 1'b1;
		flt = 8'hff;
		vok = 1'b1;
		batt = 1'b1;
		vzero = 1'b0;
		evt = 7'h00;
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		settle;
		u_host.rd(8'h00, 4, got, nak);
		chk("ident", 32'h3c07_1fff, got);
		chk("rd nak", 0, nak);
		u_host.wr(8'h02, 32'hea3c_815a, 4, nak);
		chk("wr nak", 0, nak);
		chk("cfg", 32'h5a01_3c0a, cfg[31:0]);
		u_host.rd(8'h02, 4, got, nak);
		chk("rdback", 32'h0a3c_015a, got);
		u_host.wr(8'h0e, 32'h00ff_ffaa, 3, nak);
		u_host.rd(8'h0e, 3, got, nak);
		chk("unmapped", 32'h0000_0022, got);
		u_host.wr(8'h00, 32'h0000_0000, 2, nak);
		u_host.rd(8'h00, 2, got, nak);
		chk("ro", 32'h0000_3c07, got);
		u_host.rd(8'h0b, 3, got, nak);
		chk("status", 32'h0096_770b, got);
		u_host.start_c;
		u_host.byte_x(8'h30, 1'b1, got[7:0], nak);
		u_host.stop_c;
		chk("foreign", 1, nak);
		pulse(0);
		chk("irq on", 1, irq);
		u_host.rd(8'h0a, 1, got, nak);
		chk("pending", 32'h0000_0001, got);
		u_host.wr(8'h09, 32'h0000_0000, 1, nak);
		pulse(1);
		chk("irq masked", 0, irq);
		u_host.rd(8'h0a, 1, got, nak);
		chk("masked", 32'h0000_0000, got);
		vok = 1'b0;
		settle;
		chk("drop", 32'hff7f_ff1f, cfg[31:0]);
		chk("irq en", 32'h0000_007f, {24'h0000_00, cfg[63:56]});
		cen = 1'b0;
		pulse(2);
		cen = 1'b1;
		settle;
		chk("frozen", 0, irq);
		u_host.wr(8'h02, 32'h0000_0000, 1, nak);
		vok = 1'b1;
		settle;
		chk("connect", 32'h0000_001f, {24'h0000_00, cfg[7:0]});
		vok = 1'b0;
		vzero = 1'b1;
		settle;
		u_host.wr(8'h02, 32'h0000_0000, 1, nak);
		batt = 1'b0;
		settle;
		chk("batt out", 32'h0000_001f, {24'h0000_00, cfg[7:0]});
		give_verdict;
	end
endmodule
`default_nettype wire
